// [acr_pkg.sv]
// Purpose: Shared constants and types for the calibration and readout block.
// Assumes: One 20 MHz clock; serial link pins are sampled, not clocked.
// Notes: Register addresses are five-bit fields of a command byte; opcodes are byte values on the serial link.

`default_nettype none

// -----------------------------------------------------------------------
// Constants and types
// -----------------------------------------------------------------------
package acr_pkg;
	localparam int DATA_W = 32;
	localparam int CORR_W = 24;
	localparam logic [23:0] OFC_RST = 24'h000000;
	localparam logic [23:0] GAIN_RST = 24'h400000;
	localparam logic [23:0] GAIN_MAX = 24'hffffff;
	localparam int GAIN_SHIFT = 22;
	localparam int CAL_AVG = 16;
	localparam logic [3:0] CAL_LAST = 4'hf;
	localparam logic [2:0] STROBE_HI_CYC = 3'h4;
	localparam int SETTLE_PERIODS = 64;
	localparam logic [31:0] POS_FS = 32'h7fffffff;
	localparam logic [31:0] NEG_FS = 32'h80000000;
	localparam logic [52:0] CAL_NUM = {POS_FS[30:0], 22'h000000};
	localparam int DIV_NUM_W = 53;
	localparam int DIV_DEN_W = 32;
	// Correction byte addresses on the register command path.
	localparam logic [4:0] ADDR_OFS_LO = 5'h07;
	localparam logic [4:0] ADDR_OFS_MID = 5'h08;
	localparam logic [4:0] ADDR_OFS_HI = 5'h09;
	localparam logic [4:0] ADDR_GAIN_LO = 5'h0a;
	localparam logic [4:0] ADDR_GAIN_MID = 5'h0b;
	localparam logic [4:0] ADDR_GAIN_HI = 5'h0c;
	// Command bytes; the _HI forms compare only the upper bits.
	localparam logic [7:0] OP_STREAM = 8'h10;
	localparam logic [7:0] OP_STOP = 8'h11;
	localparam logic [7:0] OP_READ = 8'h12;
	localparam logic [7:0] OP_ZCAL = 8'h60;
	localparam logic [7:0] OP_SCAL = 8'h61;
	localparam logic [6:0] OP_RESUME_HI = 7'h00;
	localparam logic [6:0] OP_STBY_HI = 7'h01;
	localparam logic [6:0] OP_SYNC_HI = 7'h02;
	localparam logic [6:0] OP_RESET_HI = 7'h03;
	localparam logic [2:0] OP_RREG_HI = 3'h1;
	localparam logic [2:0] OP_WREG_HI = 3'h2;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} acr_filt_t;

	typedef enum logic [1:0] {
		DEC_CMD,
		DEC_CNT,
		DEC_WR,
		DEC_RD
	} acr_dec_t;
endpackage

`default_nettype wire

// [acr_div.sv]
// Purpose: Serial restoring divider for the gain calibration word.
// Assumes: Start is a one-cycle pulse; den is nonzero.
// Notes: Takes NW cycles; done is a one-cycle pulse with quo valid.
`timescale 1ns/100ps
`default_nettype none

module acr_div #(
	parameter int NW = acr_pkg::DIV_NUM_W,
	parameter int DW = acr_pkg::DIV_DEN_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Operands
	input wire logic start,
	input wire logic [NW-1:0] num,
	input wire logic [DW-1:0] den,
	// Result
	output logic done,
	output logic [NW-1:0] quo
);
	import acr_pkg::*;

	typedef struct packed {
		logic busy;
		logic done;
		logic [6:0] cnt;
		logic [DW-1:0] den;
		logic [DW:0] rem;
		logic [NW-1:0] q;
	} acr_div_st_t;

	acr_div_st_t q_s;
	acr_div_st_t d_s;

	always_comb begin
		logic [DW:0] r;
		r = '0;
		d_s = q_s;
		d_s.done = 1'b0;
		if (start) begin
			d_s.busy = 1'b1;
			d_s.cnt = 7'(NW);
			d_s.den = den;
			d_s.rem = '0;
			d_s.q = num;
		end else if (q_s.busy) begin
			r = {q_s.rem[DW-1:0], q_s.q[NW-1]};
			if (r >= {1'b0, q_s.den}) begin
				d_s.rem = r - {1'b0, q_s.den};
				d_s.q = {q_s.q[NW-2:0], 1'b1};
			end else begin
				d_s.rem = r;
				d_s.q = {q_s.q[NW-2:0], 1'b0};
			end
			d_s.cnt = q_s.cnt - 7'h01;
			if (q_s.cnt == 7'h01) begin
				d_s.busy = 1'b0;
				d_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q_s <= '0;
		end else begin
			q_s <= d_s;
		end
	end

	assign done = q_s.done;
	assign quo = q_s.q;
endmodule // acr_div

`default_nettype wire

// [acr_core.sv]
// Purpose: Offset/gain correction, self calibration and serial readout.
// Assumes: filt.valid pulses once per data period; link pins are async.
// Notes: Commands arrive MSB first on din, sampled at sclk rising edges.
//
// Function
// - Stop command keeps conversions running but holds the ready strobe high.
// - When stopped, results are presented only after a read command.
// - Read command taken at eighth rising sclk; result waits for strobe fall.
// - On strobe fall the result sits on dout; host samples rising sclk.
// - After resume the first strobe comes only once the result settled.
// - Result is (filter minus offset) times gain over 400000h.
// - Correction words writable by host and updated by calibration.
// - Sinc mode passes filter output uncorrected.
// - Offset word is shifted up eight bits before subtraction.
// - Offset is signed twos complement, reset value zero.
// - Gain is unsigned, 400000h is unity and the reset value.
// - Gain scales linearly, 800000h doubles, zero gives zero.
// - Each word is three byte registers, low byte at index zero.
// - Offset calibration ends sixteen data periods after the stream command, gain calibration when the divider is done (at the sixteenth if average <= 0).
// - Offset calibration averages sixteen conversions into the offset word.
// - Offset calibration leaves gain out of the averaged path.
// - Gain calibration averages sixteen conversions and solves a full-scale gain.
// - Results leave as 32-bit twos complement, MSB first.
// - Ready strobe returns high on the first falling sclk of a readout.
`timescale 1ns/100ps
`default_nettype none

module acr_core #(
	parameter int SETTLE_PERIODS = acr_pkg::SETTLE_PERIODS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filter side
	input wire acr_pkg::acr_filt_t filt,
	input wire logic sinc_mode,
	// Serial link
	input wire logic sclk,
	input wire logic din,
	output logic dout,
	output logic result_ready_strobe_n
);
	import acr_pkg::*;

	typedef struct packed {
		logic [2:0] sclk_m;
		logic [2:0] din_m;
		logic sclk_st;
		logic din_st;
		acr_dec_t dec;
		logic [2:0] bitc;
		logic [6:0] rx;
		logic wr;
		logic [4:0] addr;
		logic [4:0] cnt;
		logic skip;
		logic [31:0] sh;
		logic strobe_n;
		logic [2:0] hi;
		logic [31:0] res;
		logic stream;
		logic rd_armed;
		logic standby;
		logic [6:0] settle;
		logic cal_pend;
		logic cal_gain;
		logic cal_run;
		logic cal_div;
		logic [3:0] cal_n;
		logic [36:0] acc;
		logic [23:0] ofc;
		logic [23:0] gain;
	} acr_st_t;

	acr_st_t q;
	acr_st_t d;

	// -------------------------------------------------------------------
	// Correction datapath
	// -------------------------------------------------------------------
	logic signed [32:0] diff_w;
	logic signed [57:0] prod_w;
	logic signed [57:0] scl_w;
	logic [31:0] sat_w;
	logic [31:0] res_w;
	logic [7:0] byte_w;
	logic agree_w;
	logic rise_w;
	logic fall_w;
	logic ld_w;
	logic div_go;
	logic [31:0] div_den;
	logic div_done;
	logic [52:0] div_quo;

	assign diff_w = $signed({filt.data[31], filt.data})
		- $signed({q.ofc[23], q.ofc, 8'h00});
	assign prod_w = diff_w * $signed({1'b0, q.gain});
	assign scl_w = prod_w >>> GAIN_SHIFT;
	always_comb begin
		if (&scl_w[57:31] || ~|scl_w[57:31]) begin
			sat_w = scl_w[31:0];
		end else begin
			sat_w = scl_w[57] ? NEG_FS : POS_FS;
		end
	end
	assign res_w = sinc_mode ? filt.data : sat_w;

	// -------------------------------------------------------------------
	// Link edge detection
	// -------------------------------------------------------------------
	assign agree_w = q.sclk_m[1] == q.sclk_m[2];
	assign rise_w = agree_w && q.sclk_m[2] && !q.sclk_st;
	assign fall_w = agree_w && !q.sclk_m[2] && q.sclk_st;
	assign byte_w = {q.rx, q.din_st};
	assign ld_w = q.hi == 3'h1;

	function automatic logic [7:0] rd_byte(input acr_st_t s,
		input logic [4:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			ADDR_OFS_LO: v = s.ofc[7:0];
			ADDR_OFS_MID: v = s.ofc[15:8];
			ADDR_OFS_HI: v = s.ofc[23:16];
			ADDR_GAIN_LO: v = s.gain[7:0];
			ADDR_GAIN_MID: v = s.gain[15:8];
			ADDR_GAIN_HI: v = s.gain[23:16];
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb begin
		logic [36:0] acc_n;
		logic [32:0] avg;
		acc_n = q.acc;
		avg = '0;
		d = q;
		div_go = 1'b0;
		div_den = '0;
		d.sclk_m = {q.sclk_m[1:0], sclk};
		d.din_m = {q.din_m[1:0], din};
		if (agree_w) begin
			d.sclk_st = q.sclk_m[2];
		end
		if (q.din_m[1] == q.din_m[2]) begin
			d.din_st = q.din_m[2];
		end
		if (fall_w) begin
			d.strobe_n = 1'b1;
			if (q.skip) begin
				d.skip = 1'b0;
			end else begin
				d.sh = {q.sh[30:0], 1'b0};
			end
		end
		if (rise_w) begin
			d.rx = byte_w[6:0];
			d.bitc = q.bitc + 3'h1;
		end
		// Strobe pulses high, then falls with the new word on dout.
		// It sits before the command decode so stop and standby cancel it.
		if (q.hi != 3'h0) begin
			d.hi = q.hi - 3'h1;
			if (ld_w) begin
				d.strobe_n = 1'b0;
				d.sh = q.res;
				d.skip = 1'b0;
				d.rd_armed = 1'b0;
			end
		end
		if (rise_w && q.bitc == 3'h7) begin
			case (q.dec)
				DEC_CMD: begin
					if (byte_w[7:5] == OP_WREG_HI || byte_w[7:5] == OP_RREG_HI) begin
						d.addr = byte_w[4:0];
						d.wr = byte_w[7:5] == OP_WREG_HI;
						d.dec = DEC_CNT;
					end else if (byte_w == OP_STREAM) begin
						d.stream = 1'b1;
						if (q.cal_pend) begin
							d.cal_pend = 1'b0;
							d.cal_run = 1'b1;
							d.cal_n = 4'h0;
							d.acc = '0;
						end
					end else if (byte_w == OP_STOP) begin
						d.stream = 1'b0;
						d.strobe_n = 1'b1;
						d.hi = 3'h0;
					end else if (byte_w == OP_READ) begin
						d.rd_armed = !q.stream;
					end else if (byte_w == OP_ZCAL || byte_w == OP_SCAL) begin
						d.cal_pend = !sinc_mode;
						d.cal_gain = byte_w[0];
					end else if (byte_w[7:1] == OP_RESUME_HI) begin
						if (q.standby) begin
							d.standby = 1'b0;
							d.settle = 7'(SETTLE_PERIODS - 1);
						end
					end else if (byte_w[7:1] == OP_STBY_HI) begin
						d.standby = 1'b1;
						d.strobe_n = 1'b1;
						d.rd_armed = 1'b0;
						d.hi = 3'h0;
					end else if (byte_w[7:1] == OP_SYNC_HI) begin
						d.settle = 7'(SETTLE_PERIODS - 1);
						d.hi = 3'h0;
					end else if (byte_w[7:1] == OP_RESET_HI) begin
						d.ofc = OFC_RST;
						d.gain = GAIN_RST;
						d.stream = 1'b1;
						d.standby = 1'b0;
						d.cal_pend = 1'b0;
						d.cal_run = 1'b0;
						d.settle = 7'(SETTLE_PERIODS - 1);
					end
				end
				DEC_CNT: begin
					d.cnt = byte_w[4:0];
					if (q.wr) begin
						d.dec = DEC_WR;
					end else begin
						d.dec = DEC_RD;
						d.sh = {rd_byte(q, q.addr), 24'h000000};
						d.skip = 1'b1;
					end
				end
				DEC_WR: begin
					case (q.addr)
						ADDR_OFS_LO: d.ofc[7:0] = byte_w;
						ADDR_OFS_MID: d.ofc[15:8] = byte_w;
						ADDR_OFS_HI: d.ofc[23:16] = byte_w;
						ADDR_GAIN_LO: d.gain[7:0] = byte_w;
						ADDR_GAIN_MID: d.gain[15:8] = byte_w;
						ADDR_GAIN_HI: d.gain[23:16] = byte_w;
						default: d.ofc = q.ofc;
					endcase
					d.addr = q.addr + 5'h01;
					d.cnt = q.cnt - 5'h01;
					if (q.cnt == 5'h00) begin
						d.dec = DEC_CMD;
					end
				end
				DEC_RD: begin
					d.addr = q.addr + 5'h01;
					d.cnt = q.cnt - 5'h01;
					if (q.cnt == 5'h00) begin
						d.dec = DEC_CMD;
					end else begin
						d.sh = {rd_byte(q, q.addr + 5'h01), 24'h000000};
						d.skip = 1'b1;
					end
				end
				default: d.dec = DEC_CMD;
			endcase
		end
		if (filt.valid && !q.standby) begin
			if (q.settle != 7'h00) begin
				d.settle = q.settle - 7'h01;
			end else if (q.cal_run) begin
				if (!q.cal_div) begin
					if (q.cal_gain) begin
						acc_n = q.acc + {{4{diff_w[32]}}, diff_w};
					end else begin
						acc_n = q.acc + {{5{filt.data[31]}}, filt.data};
					end
					d.acc = acc_n;
					d.cal_n = q.cal_n + 4'h1;
					avg = acc_n[36:4];
					if (q.cal_n == CAL_LAST && !q.cal_gain) begin
						d.ofc = avg[31:8];
						d.cal_run = 1'b0;
					end else if (q.cal_n == CAL_LAST) begin
						if (avg[32] || avg == 33'h000000000) begin
							d.gain = GAIN_MAX;
							d.cal_run = 1'b0;
						end else begin
							d.cal_div = 1'b1;
							div_go = 1'b1;
							div_den = avg[31:0];
						end
					end
				end
			end else if (q.stream || q.rd_armed) begin
				d.res = res_w;
				d.hi = STROBE_HI_CYC;
				d.strobe_n = 1'b1;
			end
		end
		if (div_done) begin
			d.gain = |div_quo[52:24] ? GAIN_MAX : div_quo[23:0];
			d.cal_div = 1'b0;
			d.cal_run = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
			q.dec <= DEC_CMD;
			q.strobe_n <= 1'b1;
			q.stream <= 1'b1;
			q.ofc <= OFC_RST;
			q.gain <= GAIN_RST;
		end else begin
			q <= d;
		end
	end

	acr_div #(
		.NW(DIV_NUM_W),
		.DW(DIV_DEN_W)
	) u_div (
		.clk(clk),
		.rst(rst),
		.start(div_go),
		.num(CAL_NUM),
		.den(div_den),
		.done(div_done),
		.quo(div_quo)
	);

	assign dout = q.sh[31];
	assign result_ready_strobe_n = q.strobe_n;

	// -------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------
	chk_strobe_gated: assert property (@(posedge clk) disable iff (rst)
		$fell(q.strobe_n) |-> $past(q.stream || q.rd_armed))
		else $error("ready strobe fell while stream stopped and no read armed");
	chk_read_armed: assert property (@(posedge clk) disable iff (rst)
		$rose(q.rd_armed) |-> $past(rise_w && q.bitc == 3'h7 && !q.stream))
		else $error("read armed outside the eighth rising sclk");
	chk_strobe_clear: assert property (@(posedge clk) disable iff (rst)
		fall_w && !ld_w |=> q.strobe_n)
		else $error("ready strobe not high after falling sclk");
	chk_load_msb: assert property (@(posedge clk) disable iff (rst)
		ld_w && !(rise_w && q.bitc == 3'h7)
		|=> !q.strobe_n && dout == $past(q.res[31]))
		else $error("dout does not show result msb at strobe fall");
	chk_settle_gate: assert property (@(posedge clk) disable iff (rst)
		$fell(q.strobe_n) |-> $past(q.settle, 5) == 7'h00)
		else $error("strobe fell before settling finished");
	chk_sinc_raw: assert property (@(posedge clk) disable iff (rst)
		filt.valid && sinc_mode && !q.standby && q.settle == 7'h00
		&& !q.cal_run && (q.stream || q.rd_armed)
		|=> q.res == $past(filt.data))
		else $error("sinc mode result was corrected");
	chk_no_wrap: assert property (@(posedge clk) disable iff (rst)
		filt.valid && !sinc_mode && !diff_w[32] |-> !res_w[31])
		else $error("positive input wrapped to negative result");
	chk_zero_acc: assert property (@(posedge clk) disable iff (rst)
		filt.valid && q.cal_run && !q.cal_div && !q.cal_gain
		&& q.settle == 7'h00 && !q.standby
		|=> q.acc == $past(q.acc) + {{5{$past(filt.data[31])}}, $past(filt.data)})
		else $error("offset calibration sample not accumulated raw");
	chk_zero_store: assert property (@(posedge clk) disable iff (rst)
		$fell(q.cal_run) && !q.cal_gain && !$past(rise_w) |-> q.ofc == q.acc[35:12])
		else $error("offset word is not the sixteen sample average");
	chk_reset_words: assert property (@(posedge clk)
		$past(rst) |-> q.ofc == OFC_RST && q.gain == GAIN_RST && q.strobe_n)
		else $error("correction words not at defaults after reset");
endmodule // acr_core

`default_nettype wire

// [acr_host.sv]
// Purpose: Host controller model on the serial command link.
// Assumes: Link clock of 400 ns, four system clocks per phase.
// Notes: Sends whole bytes only; data line is held low when idle.
`timescale 1ns/100ps
`default_nettype none

module acr_host (
	// Clock
	input wire logic clk,
	// Serial link
	output logic sclk,
	output logic din,
	input wire logic dout
);
	// -------------------------------------------------------------------
	// Byte transfer
	// -------------------------------------------------------------------
	initial begin
		sclk = 1'b0;
		din = 1'b0;
	end

	// The link clock stands low between bytes, so it only runs in frames.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			din = tx[i];
			repeat (4) @(negedge clk);
			rx[i] = dout;
			sclk = 1'b1;
			repeat (4) @(negedge clk);
			sclk = 1'b0;
		end
		din = 1'b0;
		repeat (24) @(negedge clk);
	endtask
endmodule // acr_host

`default_nettype wire

// [adc_calibration_readout_bench.sv]
// Purpose: Self-checking bench for the correction and readout core.
// Assumes: Settling shortened to two data periods.
// Notes: Results are compared with a behavioural correction model.
`timescale 1ns/100ps
`default_nettype none

module adc_calibration_readout_bench;
	import acr_pkg::*;
	logic clk, rst, sinc_mode, sclk, din, dout, result_ready_strobe_n;
	acr_filt_t filt;
	int num_errors, checked, cycles;
	logic [15:0] seed;
	logic [23:0] ofc_m, gain_m;
	logic [7:0] b;

	acr_core #(.SETTLE_PERIODS(2)) DUT (.clk(clk), .rst(rst), .filt(filt),
		.sinc_mode(sinc_mode), .sclk(sclk), .din(din), .dout(dout),
		.result_ready_strobe_n(result_ready_strobe_n));
	acr_host host (.clk(clk), .sclk(sclk), .din(din), .dout(dout));

	// -------------------------------------------------------------------
	// Clock, timeout and helpers
	// -------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic logic [31:0] rnd();
		logic [31:0] r;
		for (int i = 0; i < 32; i++) begin
			seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
			r = {r[30:0], seed[0]};
		end
		return r;
	endfunction

	// Corrected result, saturated at the 32-bit extremes.
	function automatic logic [31:0] model(logic [31:0] d);
		longint p;
		if (sinc_mode) return d;
		p = longint'($signed(d)) - (longint'($signed(ofc_m)) <<< 8);
		p = (p * longint'(gain_m)) >>> 22;
		if (p > 64'sh7fffffff) return 32'h7fffffff;
		if (p < -64'sh80000000) return 32'h80000000;
		return p[31:0];
	endfunction

	task automatic cmd(logic [7:0] c);
		host.xfer(c, b);
	endtask

	task automatic pulse(logic [31:0] d, logic fall);
		@(negedge clk);
		filt.valid = 1'b1;
		filt.data = d;
		@(negedge clk);
		filt.valid = 1'b0;
		repeat (6) @(negedge clk);
		check("strobe", result_ready_strobe_n, !fall);
	endtask

	task automatic get(logic [31:0] d);
		logic [31:0] w;
		host.xfer(8'h00, w[31:24]);
		check("strobe after fall", result_ready_strobe_n, 1);
		host.xfer(8'h00, w[23:16]);
		host.xfer(8'h00, w[15:8]);
		host.xfer(8'h00, w[7:0]);
		check("result", w, model(d));
	endtask

	task automatic wreg(logic [23:0] o, logic [23:0] g);
		logic [47:0] v;
		v = {g, o};
		ofc_m = o;
		gain_m = g;
		cmd(8'h47);
		cmd(8'h05);
		for (int i = 0; i < 6; i++) cmd(v[8*i +: 8]);
	endtask

	// Reads seven bytes from the offset low byte; the last is unmapped.
	task automatic regs_check();
		logic [7:0] e [7];
		e = '{ofc_m[7:0], ofc_m[15:8], ofc_m[23:16], gain_m[7:0],
			gain_m[15:8], gain_m[23:16], 8'h00};
		cmd(8'h27);
		cmd(8'h06);
		for (int i = 0; i < 7; i++) begin
			host.xfer(8'h00, b);
			check("register byte", b, e[i]);
		end
	endtask

	// -------------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------------
	initial begin
		logic [31:0] d, r;
		logic [23:0] gains [5];
		longint sum, avg, q;
		filt = '0;
		sinc_mode = 1'b0;
		rst = 1'b1;
		seed = 16'h2b25;
		num_errors = 0;
		checked = 0;
		cycles = 0;
		ofc_m = 24'h000000;
		gain_m = 24'h400000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		d = rnd();
		pulse(d, 1);
		get(d);
		cmd(OP_STOP);
		regs_check();
		pulse(rnd(), 0);
		cmd(OP_READ);
		check("strobe before data", result_ready_strobe_n, 1);
		d = rnd();
		pulse(d, 1);
		get(d);
		pulse(rnd(), 0);
		gains = '{24'h800000, 24'h200000, 24'h000000, 24'h400000, 24'h0};
		gains[4] = 24'(rnd());
		for (int i = 0; i < 5; i++) begin
			wreg(24'(rnd()), gains[i]);
			regs_check();
			sinc_mode = (i == 3);
			cmd(OP_READ);
			d = rnd();
			pulse(d, 1);
			get(d);
		end
		sinc_mode = 1'b0;
		// Streaming: standby, resume, settle, read, standby, resume.
		cmd(OP_STREAM);
		cmd(8'h02);
		pulse(rnd(), 0);
		cmd(8'h00);
		pulse(rnd(), 0);
		d = rnd();
		pulse(d, 1);
		get(d);
		cmd(8'h02);
		cmd(8'h00);
		// Offset then gain calibration; sync pin is not modelled.
		for (int k = 0; k < 2; k++) begin
			cmd(OP_STOP);
			cmd(8'h04);
			cmd(OP_STREAM);
			pulse(rnd(), 0);
			pulse(rnd(), 1);
			cmd(OP_STOP);
			cmd(k ? OP_SCAL : OP_ZCAL);
			cmd(OP_STREAM);
			sum = 0;
			for (int i = 0; i < 16; i++) begin
				r = rnd();
				d = {1'b0, k[0], 10'h000, r[19:0]};
				sum += longint'(d);
				if (k == 1) sum -= longint'($signed(ofc_m)) <<< 8;
				pulse(d, 0);
			end
			repeat (80) @(negedge clk);
			avg = sum / 16;
			q = (longint'(32'h7fffffff) <<< 22) / avg;
			if (k == 0) ofc_m = avg[31:8];
			else gain_m = (q > 64'sh0ffffff) ? 24'hffffff : q[23:0];
			d = rnd();
			pulse(d, 1);
			get(d);
			cmd(OP_STOP);
			regs_check();
		end
		// Reset command restores both words and restarts streaming.
		cmd(8'h06);
		ofc_m = 24'h000000;
		gain_m = 24'h400000;
		pulse(rnd(), 0);
		d = rnd();
		pulse(d, 1);
		get(d);
		cmd(OP_STOP);
		regs_check();
		conclude();
	end
endmodule // adc_calibration_readout_bench

`default_nettype wire
